/* File: hw/igr_pkg.sv */
// Shared constants, types and decode helpers for the ion gauge remote control block
package igr_pkg;
  // Clock rate in kHz, so that ms * kHz gives cycles without overflow
  localparam int CLK_KHZ       = 125000;
  localparam int REM_LOW_MS    = 25;    // Least low time of a remote press
  localparam int REM_HIGH_MS   = 105;   // Least high time before next press
  localparam int DISP_TICK_MS  = 1;     // Display bus update period
  localparam int WDOG_MS       = 100;   // Watchdog checkpoint window
  localparam int REM_LOW_CYC   = REM_LOW_MS * CLK_KHZ;
  localparam int REM_HIGH_CYC  = REM_HIGH_MS * CLK_KHZ;
  localparam int DISP_TICK_CYC = DISP_TICK_MS * CLK_KHZ;
  localparam int WDOG_TO_CYC   = WDOG_MS * CLK_KHZ;
  localparam int WDOG_RST_CYC  = 16;    // Length of a watchdog reset
  localparam int CNT_W         = 24;    // Width of the long timers
  localparam int ADDR_W        = 5;
  localparam int DATA_W        = 32;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CMD  = 5'h00;
  localparam logic [ADDR_W-1:0] REG_CFG  = 5'h04;
  localparam logic [ADDR_W-1:0] REG_STAT = 5'h08;
  localparam logic [ADDR_W-1:0] REG_MSG  = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_CAP  = 5'h10;
  // Command bits, write one to act
  localparam int CMD_G1_ON  = 0;
  localparam int CMD_G1_OFF = 1;
  localparam int CMD_G2_ON  = 2;
  localparam int CMD_G2_OFF = 3;
  localparam int CMD_DG_ON  = 4;
  localparam int CMD_DG_OFF = 5;
  localparam int CMD_W      = 6;
  // Status bit of the sticky refusal flag
  localparam int STAT_REFUSED = 6;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [3:0] MSG_SLOT    = 4'hf;
  // Degas pressure limits, BCD mantissa d.d and signed exponent
  localparam logic [7:0]        TORR_MANT = 8'h50;
  localparam logic signed [4:0] TORR_EXP  = 5'sh1b;  // -5
  localparam logic [7:0]        PA_MANT   = 8'h66;
  localparam logic signed [4:0] PA_EXP    = 5'sh1d;  // -3
  // Remote input qualifier states, Gray along the path
  typedef enum logic [1:0] {
    Q_IDLE = 2'b00,
    Q_LOW  = 2'b01,
    Q_HELD = 2'b11,
    Q_REL  = 2'b10
  } igr_q_e;
  // True when the pressure lies below the degas limit of the units
  function automatic logic igr_degas_ok(input logic [7:0] mant,
                                        input logic signed [4:0] ex,
                                        input logic pa);
    logic signed [4:0] le;
    logic [7:0]        lm;
    le = pa ? PA_EXP : TORR_EXP;
    lm = pa ? PA_MANT : TORR_MANT;
    return (ex < le) || ((ex == le) && (mant < lm));
  endfunction : igr_degas_ok
endpackage : igr_pkg

/* File: hw/igr_qual.sv */
// Press qualifier: synchroniser, least low time and least high time
`timescale 1ns/1ns
module igr_qual
  import igr_pkg::*;
#(
  parameter int LOW_CYC  = REM_LOW_CYC,
  parameter int HIGH_CYC = REM_HIGH_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic pin_n_i,   // Active low key or remote pin
  output logic      press_o    // One cycle per recognised press
);
  logic             s1_reg;    // First synchroniser stage
  logic             s2_reg;    // Second stage, the only one read
  igr_q_e           st_reg;    // Qualifier state
  logic [CNT_W-1:0] cnt_reg;   // Low or high duration counter
  wire low_done  = (cnt_reg == CNT_W'(LOW_CYC - 1));
  wire high_done = (cnt_reg == CNT_W'(HIGH_CYC - 1));

  //////////////////////////////////////////////////////////////////
  // two-stage sync
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
    end
    else if (ce_i)
    begin
      s1_reg <= pin_n_i;
      s2_reg <= s1_reg;
    end

  // duration state machine; bounce restarts the count
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      st_reg  <= Q_IDLE;
      cnt_reg <= '0;
      press_o <= 1'b0;
    end
    else if (ce_i)
    begin
      press_o <= 1'b0;
      cnt_reg <= cnt_reg + 1'b1;
      case (st_reg)
        Q_IDLE:                        // Wait for a low
        begin
          cnt_reg <= '0;
          if (!s2_reg) st_reg <= Q_LOW;
        end
        Q_LOW:                         // Low must last unbroken
          if (s2_reg) st_reg <= Q_IDLE;
          else if (low_done)
          begin
            press_o <= 1'b1;
            st_reg  <= Q_HELD;
          end
        Q_HELD:                        // Still low after recognition
        begin
          cnt_reg <= '0;
          if (s2_reg) st_reg <= Q_REL;
        end
        Q_REL:                         // A new low returns to held, no press
          if (!s2_reg) st_reg <= Q_HELD;
          else if (high_done) st_reg <= Q_IDLE;
        default: st_reg <= Q_IDLE;
      endcase
    end

  //////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_low_done;
    ce_i && st_reg == Q_LOW && !s2_reg && low_done;
  endsequence
  property p_press_after_low;
    s_low_done |=> press_o;
  endproperty
  a_press_after_low: assert property (p_press_after_low)
    else $error("press not raised after full low time");
  property p_no_early_press;
    ce_i && st_reg != Q_LOW |=> !press_o;
  endproperty
  a_no_early_press: assert property (p_no_early_press)
    else $error("press outside the low qualification state");
endmodule : igr_qual

/* File: hw/igr_wdog.sv */
// Watchdog: resets the processor when a checkpoint is missed
`timescale 1ns/1ns
module igr_wdog
  import igr_pkg::*;
#(
  parameter int TO_CYC = WDOG_TO_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic kick_i,   // Checkpoint pulse, same clock
  output logic      wrst_o    // Processor reset, level
);
  logic [CNT_W-1:0] cnt_reg;  // Time since last checkpoint
  logic [4:0]       rc_reg;   // Remaining reset cycles
  wire expire = (cnt_reg == CNT_W'(TO_CYC - 1)) && !kick_i;

  //////////////////////////////////////////////////////////////////
  // timeout raises a fixed-length reset
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      cnt_reg <= '0;
      rc_reg  <= '0;
      wrst_o  <= 1'b0;
    end
    else if (ce_i)
    begin
      cnt_reg <= (kick_i || expire) ? '0 : cnt_reg + 1'b1;
      if (expire) rc_reg <= 5'(WDOG_RST_CYC - 1);
      else if (rc_reg != '0) rc_reg <= rc_reg - 1'b1;
      wrst_o  <= expire || (rc_reg != '0);
    end

  property p_expire_reset;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && expire |=> wrst_o;
  endproperty
  a_expire_reset: assert property (p_expire_reset)
    else $error("watchdog did not reset after timeout");
endmodule : igr_wdog

/* File: hw/igr_top.sv */
// Ion gauge remote control: switching, interlocks, relays, display bus
`timescale 1ns/1ns
module igr_top
  import igr_pkg::*;
#(
  parameter int REM_LOW_CYC_P   = REM_LOW_CYC,
  parameter int REM_HIGH_CYC_P  = REM_HIGH_CYC,
  parameter int DISP_TICK_CYC_P = DISP_TICK_CYC,
  parameter int WDOG_TO_CYC_P   = WDOG_TO_CYC
) (
  input  wire logic              CLK_I,
  input  wire logic              SYS_RST_I,
  input  wire logic              CE_I,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input  wire logic              S_AXI_AWVALID_I,
  output logic                   S_AXI_AWREADY_O,
  input  wire logic [DATA_W-1:0] S_AXI_WDATA_I,
  input  wire logic [3:0]        S_AXI_WSTRB_I,
  input  wire logic              S_AXI_WVALID_I,
  output logic                   S_AXI_WREADY_O,
  output logic [1:0]             S_AXI_BRESP_O,
  output logic                   S_AXI_BVALID_O,
  input  wire logic              S_AXI_BREADY_I,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input  wire logic              S_AXI_ARVALID_I,
  output logic                   S_AXI_ARREADY_O,
  output logic [DATA_W-1:0]      S_AXI_RDATA_O,
  output logic [1:0]             S_AXI_RRESP_O,
  output logic                   S_AXI_RVALID_O,
  input  wire logic              S_AXI_RREADY_I,
  // Front panel keys and rear remote pins, all active low except FAULT_SRC_DEGAS_I
  input  wire logic              KEY_G1_N_I,
  input  wire logic              KEY_G2_N_I,
  input  wire logic              KEY_DEGAS_N_I,
  input  wire logic              REM_G1_N_I,
  input  wire logic              REM_G2_N_I,
  input  wire logic              REM_DEGAS_N_I,
  input  wire logic              KEY_INHIBIT_N_I,
  input  wire logic              GAUGE_INHIBIT_N_I,
  input  wire logic              FAULT_SRC_DEGAS_I,
  // Same-clock logic inputs
  input  wire logic [1:0]        AUTO_ON_I,
  input  wire logic [7:0]        PRESS_MANT_I,
  input  wire logic [4:0]        PRESS_EXP_I,
  input  wire logic              FAULT_DET_I,
  input  wire logic              WDOG_KICK_I,
  // Relays and outputs
  output logic                   FIL1_RELAY_O,
  output logic                   FIL2_RELAY_O,
  output logic                   FAULT_RELAY_O,
  output logic                   DEGAS_ON_O,
  output logic                   WDOG_RST_O,
  output logic                   DISP_STB_O,
  output logic [3:0]             DISP_SLOT_O,
  output logic [7:0]             DISP_DATA_O
);
  //////////////////////////////////////////////////////////////////
  // Declarations
  logic [5:0]        ev;          // Press pulses: keys 2:0, remotes 5:3
  logic [2:0]        lv1_reg;     // First sync stage of level pins
  logic [2:0]        lv2_reg;     // Second sync stage
  logic [1:0]        g_reg;       // Gauge filaments on
  logic              dg_reg;      // Degas on
  logic              relay_reg;   // Fault relay drive
  logic              pa_reg;      // Pascal units selected
  logic              ref_reg;     // Sticky refusal flag
  logic [7:0]        msg_reg;     // Inter-processor message byte
  logic [7:0]        cap_m_reg;   // Captured mantissa
  logic [4:0]        cap_e_reg;   // Captured exponent
  logic [CMD_W-1:0]  cmd_reg;     // Command pulses from software
  logic [16:0]       tick_reg;    // Millisecond divider
  logic              aw_full_reg; // Held write address
  logic [ADDR_W-1:0] awa_reg;
  logic              w_full_reg;  // Held write data
  logic [DATA_W-1:0] wd_reg;
  logic              ws0_reg;     // Low byte lane enabled
  logic [1:0]        g_next;
  logic              dg_next;
  logic [DATA_W-1:0] rd_next;

  //////////////////////////////////////////////////////////////////
  // keys and remotes share one qualifier design
  localparam logic [5:0] PIN_ZERO = 6'h00;
  wire [5:0] pins_n = {REM_DEGAS_N_I, REM_G2_N_I, REM_G1_N_I,
                       KEY_DEGAS_N_I, KEY_G2_N_I, KEY_G1_N_I} | PIN_ZERO;
  for (genvar i = 0; i < 6; i++)
  begin : g_qual
    igr_qual #(
      .LOW_CYC  (REM_LOW_CYC_P),
      .HIGH_CYC (REM_HIGH_CYC_P)
    ) u_qual (
      .clk_i   (CLK_I),
      .rst_i   (SYS_RST_I),
      .ce_i    (CE_I),
      .pin_n_i (pins_n[i]),
      .press_o (ev[i])
    );
  end

  igr_wdog #(
    .TO_CYC (WDOG_TO_CYC_P)
  ) u_wdog (
    .clk_i  (CLK_I),
    .rst_i  (SYS_RST_I),
    .ce_i   (CE_I),
    .kick_i (WDOG_KICK_I),
    .wrst_o (WDOG_RST_O)
  );

  // Level pins: inhibits and jumper, two stages before use
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
    if (SYS_RST_I)
    begin
      lv1_reg <= 3'h3;
      lv2_reg <= 3'h3;
    end
    else if (CE_I)
    begin
      lv1_reg <= {FAULT_SRC_DEGAS_I, GAUGE_INHIBIT_N_I, KEY_INHIBIT_N_I};
      lv2_reg <= lv1_reg;
    end

  wire key_inh   = !lv2_reg[0];
  wire gauge_inh = !lv2_reg[1];
  wire jmp_degas = lv2_reg[2];

  //////////////////////////////////////////////////////////////////
  // Request decode
  // panel keys gated by key inhibit
  wire [2:0] key_ev = ev[2:0] & {3{!key_inh}};
  // a press toggles; key or remote
  wire [2:0] tog = key_ev | ev[5:3];
  // three sources of gauge on, two of gauge off and of degas
  wire on1  = (tog[0] & !g_reg[0]) | AUTO_ON_I[0] | cmd_reg[CMD_G1_ON];
  wire on2  = (tog[1] & !g_reg[1]) | AUTO_ON_I[1] | cmd_reg[CMD_G2_ON];
  wire off1 = (tog[0] & g_reg[0]) | cmd_reg[CMD_G1_OFF];
  wire off2 = (tog[1] & g_reg[1]) | cmd_reg[CMD_G2_OFF];
  wire dg_on  = (tog[2] & !dg_reg) | cmd_reg[CMD_DG_ON];
  wire dg_off = (tog[2] & dg_reg) | cmd_reg[CMD_DG_OFF];
  // pressure limit in the units selected
  wire p_ok  = igr_degas_ok(PRESS_MANT_I, $signed(PRESS_EXP_I), pa_reg);
  wire dg_ok = p_ok && (g_next != 2'b00);
  wire refuse = ((on1 | on2) & gauge_inh) | (dg_on & !dg_ok);
  wire fault_w = FAULT_DET_I | WDOG_RST_O;

  // Next gauge state; gauge one wins a same-cycle tie
  always_comb
  begin
    // inhibit forces both off, refuses on
    if (gauge_inh) g_next = 2'b00;
    // turning one on turns the other off
    else if (on1) g_next = 2'b01;
    else if (on2) g_next = 2'b10;
    else g_next = g_reg & ~{off2, off1};
  end

  // Degas needs a running gauge; it drops with the gauge
  always_comb
  begin
    if (g_next == 2'b00) dg_next = 1'b0;
    else if (dg_on && dg_ok) dg_next = 1'b1;
    else if (dg_off) dg_next = 1'b0;
    else dg_next = dg_reg;
  end

  //////////////////////////////////////////////////////////////////
  // Gauge, degas and relay state
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
    if (SYS_RST_I)
    begin
      g_reg     <= 2'b00;
      dg_reg    <= 1'b0;
      relay_reg <= 1'b0;
    end
    else if (CE_I)
    begin
      g_reg     <= g_next;
      dg_reg    <= dg_next;
      // energised unless fault, or degas by jumper
      relay_reg <= jmp_degas ? dg_reg : !fault_w;
    end

  assign FIL1_RELAY_O  = g_reg[0];
  assign FIL2_RELAY_O  = g_reg[1];
  assign FAULT_RELAY_O = relay_reg;
  assign DEGAS_ON_O    = dg_reg;

  //////////////////////////////////////////////////////////////////
  // Display bus: one slot per ms, sixteen slots a frame
  wire tick = (tick_reg == 17'(DISP_TICK_CYC_P - 1));
  wire [3:0] slot_n = DISP_SLOT_O + 4'h1;

  always_ff @(posedge CLK_I or posedge SYS_RST_I)
    if (SYS_RST_I)
    begin
      tick_reg    <= '0;
      DISP_STB_O  <= 1'b0;
      DISP_SLOT_O <= MSG_SLOT;
      DISP_DATA_O <= 8'h00;
    end
    else if (CE_I)
    begin
      tick_reg   <= tick ? '0 : tick_reg + 1'b1;
      DISP_STB_O <= tick;
      if (tick)
      begin
        DISP_SLOT_O <= slot_n;
        // Message slot, else mantissa on even and exponent on odd
        DISP_DATA_O <= (slot_n == MSG_SLOT) ? msg_reg :
                       slot_n[0] ? {3'h0, PRESS_EXP_I} : PRESS_MANT_I;
      end
    end

  // capture pressure from the bus itself
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
    if (SYS_RST_I)
    begin
      cap_m_reg <= 8'h00;
      cap_e_reg <= 5'h00;
    end
    else if (CE_I && DISP_STB_O && DISP_SLOT_O != MSG_SLOT)
    begin
      if (DISP_SLOT_O[0]) cap_e_reg <= DISP_DATA_O[4:0];
      else cap_m_reg <= DISP_DATA_O;
    end

  //////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data held until both are present
  assign S_AXI_AWREADY_O = CE_I && !aw_full_reg;
  assign S_AXI_WREADY_O  = CE_I && !w_full_reg;
  wire wr_go  = aw_full_reg && w_full_reg && !S_AXI_BVALID_O;
  wire wr_lo  = wr_go && ws0_reg;
  wire wr_cmd = wr_lo && awa_reg == REG_CMD;
  wire wr_cfg = wr_lo && awa_reg == REG_CFG;
  wire wr_st  = wr_lo && awa_reg == REG_STAT;
  wire wr_msg = wr_lo && awa_reg == REG_MSG;
  wire wr_map = awa_reg == REG_CMD || awa_reg == REG_CFG ||
                awa_reg == REG_STAT || awa_reg == REG_MSG;

  // Channel holding registers and write response
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
    if (SYS_RST_I)
    begin
      aw_full_reg    <= 1'b0;
      awa_reg        <= '0;
      w_full_reg     <= 1'b0;
      wd_reg         <= '0;
      ws0_reg        <= 1'b0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= RESP_OKAY;
    end
    else if (CE_I)
    begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
      begin
        aw_full_reg <= 1'b1;
        awa_reg     <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O)
      begin
        w_full_reg <= 1'b1;
        wd_reg     <= S_AXI_WDATA_I;
        ws0_reg    <= S_AXI_WSTRB_I[0];
      end
      if (wr_go)
      begin
        aw_full_reg    <= 1'b0;
        w_full_reg     <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (S_AXI_BREADY_I) S_AXI_BVALID_O <= 1'b0;
    end

  // Software state; refusal flag set wins over the clear
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
    if (SYS_RST_I)
    begin
      cmd_reg <= '0;
      pa_reg  <= 1'b0;
      ref_reg <= 1'b0;
      msg_reg <= 8'h00;
    end
    else if (CE_I)
    begin
      cmd_reg <= wr_cmd ? wd_reg[CMD_W-1:0] : '0;
      if (wr_cfg) pa_reg <= wd_reg[0];
      if (wr_msg) msg_reg <= wd_reg[7:0];
      ref_reg <= refuse || (ref_reg && !(wr_st && wd_reg[STAT_REFUSED]));
    end

  //////////////////////////////////////////////////////////////////
  // AXI4-Lite read: one outstanding, answer one cycle after address
  assign S_AXI_ARREADY_O = CE_I && !S_AXI_RVALID_O;
  wire rd_map = S_AXI_ARADDR_I == REG_CFG || S_AXI_ARADDR_I == REG_STAT ||
                S_AXI_ARADDR_I == REG_MSG || S_AXI_ARADDR_I == REG_CAP ||
                S_AXI_ARADDR_I == REG_CMD;

  // Read data select; command register reads zero
  always_comb
  begin
    rd_next = '0;
    case (S_AXI_ARADDR_I)
      REG_CFG:  rd_next[0] = pa_reg;
      REG_STAT: rd_next[6:0] = {ref_reg, gauge_inh, key_inh, fault_w,
                                dg_reg, g_reg};
      REG_MSG:  rd_next[7:0] = msg_reg;
      REG_CAP:  rd_next[12:0] = {cap_e_reg, cap_m_reg};
      default:  rd_next = '0;
    endcase
  end

  // Read response register
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
    if (SYS_RST_I)
    begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O  <= '0;
      S_AXI_RRESP_O  <= RESP_OKAY;
    end
    else if (CE_I)
    begin
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
      begin
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RDATA_O  <= rd_next;
        S_AXI_RRESP_O  <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (S_AXI_RREADY_I) S_AXI_RVALID_O <= 1'b0;
    end

  //////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  property p_one_gauge;
    !(g_reg[0] && g_reg[1]);
  endproperty
  a_one_gauge: assert property (p_one_gauge)
    else $error("both gauges on");
  property p_inhibit_off;
    CE_I && gauge_inh |=> g_reg == 2'b00;
  endproperty
  a_inhibit_off: assert property (p_inhibit_off)
    else $error("gauge left on under inhibit");
  property p_degas_gate;
    $rose(dg_reg) |-> $past(p_ok) && g_reg != 2'b00;
  endproperty
  a_degas_gate: assert property (p_degas_gate)
    else $error("degas started above the limit");
  property p_key_toggle;
    CE_I && key_ev[0] && g_reg[0] && !gauge_inh && !on2 && !AUTO_ON_I[0]
      && !cmd_reg[CMD_G1_ON] |=> !g_reg[0];
  endproperty
  a_key_toggle: assert property (p_key_toggle)
    else $error("key press did not turn gauge off");
  property p_key_inhibit;
    CE_I && key_inh && !g_reg[0] && !ev[3] && !AUTO_ON_I[0]
      && !cmd_reg[CMD_G1_ON] |=> !g_reg[0];
  endproperty
  a_key_inhibit: assert property (p_key_inhibit)
    else $error("gauge started by an inhibited key");
  property p_fault_relay;
    CE_I && !jmp_degas |=> FAULT_RELAY_O == !$past(fault_w);
  endproperty
  a_fault_relay: assert property (p_fault_relay)
    else $error("fault relay does not follow fault");
  property p_jumper_degas;
    CE_I && jmp_degas |=> FAULT_RELAY_O == $past(dg_reg);
  endproperty
  a_jumper_degas: assert property (p_jumper_degas)
    else $error("fault relay does not follow degas");
  property p_strobe_pulse;
    DISP_STB_O && CE_I |=> !DISP_STB_O;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("display strobe longer than a cycle");
  property p_msg_slot;
    CE_I && tick && slot_n == MSG_SLOT |=> DISP_DATA_O == $past(msg_reg);
  endproperty
  a_msg_slot: assert property (p_msg_slot)
    else $error("message slot carries wrong data");
  property p_capture;
    CE_I && DISP_STB_O && DISP_SLOT_O != MSG_SLOT && !DISP_SLOT_O[0]
      |=> cap_m_reg == $past(DISP_DATA_O);
  endproperty
  a_capture: assert property (p_capture)
    else $error("mantissa not captured from bus");
endmodule : igr_top

/* File: testbench/igr_remote_model.sv */
// Rear contact closure model driving the active low key and remote pins
`timescale 1ns/1ns
module igr_remote_model #(
  parameter int LOW_CYC = 12
) (
  input  wire logic       clk_i,
  input  wire logic [5:0] go_i,     // Start one closure per pin
  output logic      [5:0] pin_n_o   // Pulled up when the contact opens
);
  int cnt [6] = '{default: 0};      // Low cycles left per pin
  ////////////////////////////////////////////////////////////////
  // closure length, then open
  always @(posedge clk_i)
    for (int i = 0; i < 6; i++)
      cnt[i] <= go_i[i] ? LOW_CYC : ((cnt[i] > 0) ? cnt[i] - 1 : 0);
  // Pull-up: an open contact reads high, never the last value
  always_comb
    for (int i = 0; i < 6; i++)
      pin_n_o[i] = !(cnt[i] > 0);
endmodule : igr_remote_model

/* File: testbench/igr_top_tb_top.sv */
// Self-checking bench for the gauge switching block
`timescale 1ns/1ns
module igr_top_tb_top;
  import igr_pkg::*;
  logic clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, kin = 1, gin = 1, jmp = 0;
  logic [4:0] awa = 0, ara = 0, pex = 5'h1c;
  logic [31:0] wd = 0, rdv;
  logic [7:0] pm = 8'h10;
  logic [5:0] go = 0, pin;
  logic fdet = 0, kick = 0, awr, wr_, bv, arr, rv, f1, f2, fr, dg, stb, wrst, ce = 1, nok = 0;
  logic [1:0] bresp, rresp, wb, ao = 0;
  logic [3:0] ws = 4'hf;
  logic [7:0] dd;
  logic [3:0] slot;
  int failures = 0, checks_done = 0, cyc = 0;
  always #4 clk = ~clk;
  igr_remote_model #(.LOW_CYC(12)) model_u (.clk_i(clk), .go_i(go), .pin_n_o(pin));
  igr_top #(.REM_LOW_CYC_P(8), .REM_HIGH_CYC_P(12), .DISP_TICK_CYC_P(10), .WDOG_TO_CYC_P(50))
  dut_u (.CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr_), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdv),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .KEY_G1_N_I(pin[0]),
    .KEY_G2_N_I(pin[1]), .KEY_DEGAS_N_I(pin[2]), .REM_G1_N_I(pin[3]), .REM_G2_N_I(pin[4]),
    .REM_DEGAS_N_I(pin[5]), .KEY_INHIBIT_N_I(kin), .GAUGE_INHIBIT_N_I(gin),
    .FAULT_SRC_DEGAS_I(jmp), .AUTO_ON_I(ao), .PRESS_MANT_I(pm), .PRESS_EXP_I(pex),
    .FAULT_DET_I(fdet), .WDOG_KICK_I(kick), .FIL1_RELAY_O(f1), .FIL2_RELAY_O(f2),
    .FAULT_RELAY_O(fr), .DEGAS_ON_O(dg), .WDOG_RST_O(wrst), .DISP_STB_O(stb),
    .DISP_SLOT_O(slot), .DISP_DATA_O(dd));
  ////////////////////////////////////////////////////////////////
  // Timeout and checkpoint kicks, so the watchdog stays quiet
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    kick <= !nok && (cyc % 20) == 0;
    if (cyc == 20000)
    begin
      failures++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Write: both beats offered together, each dropped when taken
  task automatic axw(input logic [4:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 0; tw = 0;
    awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
    while (!(ta && tw))
    begin
      @(posedge clk);
      if (awr && !ta) begin ta = 1; awv <= 0; end
      if (wr_ && !tw) begin tw = 1; wv <= 0; end
    end
    do @(posedge clk); while (!bv);
    // Response code taken at the handshake edge
    wb = bresp;
    br <= 0;
    repeat (3) @(posedge clk);
  endtask : axw
  task automatic axr(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a; arv <= 1; rr <= 1;
    do @(posedge clk); while (!arr);
    arv <= 0;
    do @(posedge clk); while (!rv);
    d = rdv; r = rresp; rr <= 0;
    @(posedge clk);
  endtask : axr
  // One closure on one pin, then a full high window
  task automatic press(input int i);
    go[i] <= 1;
    @(posedge clk);
    go[i] <= 0;
    repeat (40) @(posedge clk);
  endtask : press
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] s;
    int n;
    repeat (6) @(posedge clk);
    rst <= 0;
    repeat (3) @(posedge clk);
    chk({f1, f2, fr}, 3'b001);
    press(3); chk(f1, 1);
    press(1); chk({f1, f2}, 2'b01);
    press(1); chk(f2, 0);
    // Second closure inside the high window must be dropped
    go[3] <= 1; @(posedge clk); go[3] <= 0; repeat (16) @(posedge clk);
    press(3); chk(f1, 1);
    $display("panel and remote test done");
    axw(REG_CMD, 32'h2); chk(f1, 0);
    chk(wb, RESP_OKAY);
    axw(REG_CMD, 32'h1); chk(f1, 1);
    axw(REG_CMD, 32'h10); chk(dg, 0);
    axr(REG_STAT, d, r); chk(d[STAT_REFUSED], 1);
    pm <= 8'h49; pex <= 5'h1b; jmp <= 1;
    axw(REG_CMD, 32'h10); chk({dg, fr}, 2'b11);
    press(2); chk({dg, fr}, 2'b00);
    jmp <= 0; fdet <= 1; repeat (5) @(posedge clk); chk(fr, 0);
    fdet <= 0;
    $display("degas and fault test done");
    gin <= 0; repeat (5) @(posedge clk); chk(f1, 0);
    axw(REG_CMD, 32'h4); chk(f2, 0);
    gin <= 1; kin <= 0; repeat (5) @(posedge clk);
    press(0); chk(f1, 0);
    kin <= 1;
    axr(5'h14, d, r); chk(r, RESP_SLVERR);
    axw(5'h14, 32'h1); chk(wb, RESP_SLVERR);
    do @(posedge clk); while (!stb);
    // Slot wraps from 15 to 0, so the sum is cut to four bits
    s = slot + 4'h1;
    do @(posedge clk); while (!stb);
    chk(slot, s);
    // Low byte strobe off: the message write must not land
    ws <= 4'h0;
    axw(REG_MSG, 32'ha5); axr(REG_MSG, d, r); chk(d, 0);
    ws <= 4'hf;
    axw(REG_MSG, 32'h3c);
    do @(posedge clk); while (!(stb && slot == MSG_SLOT));
    chk(dd, 8'h3c);
    axr(REG_CAP, d, r); chk(d, 32'h1b49);
    ao <= 2'b10; @(posedge clk); ao <= 2'b00;
    repeat (3) @(posedge clk); chk(f2, 1);
    // Enable low freezes the display slot
    ce <= 0; @(posedge clk); s = slot;
    repeat (30) @(posedge clk); chk(slot, s);
    ce <= 1; nok <= 1;
    // Kicks withheld: count the cycles of processor reset
    do @(posedge clk); while (!wrst);
    n = 0;
    while (wrst)
    begin
      n++;
      @(posedge clk);
    end
    nok <= 0;
    chk(n, 16);
    $display("inhibit and bus test done");
    complete_run();
  end
endmodule : igr_top_tb_top
